// ### pss_map.vh
`ifndef PSS_MAP_VH
`define PSS_MAP_VH

// ==========================================================================
// Register word addresses.
`define PSS_A_HIGH      8'h00
`define PSS_A_MIDDLE    8'h01
`define PSS_A_LOW       8'h02
`define PSS_A_INCH_FREQ 8'h03
`define PSS_A_INCH_RAMP 8'h04
`define PSS_A_RAMP_REF  8'h05
`define PSS_A_REMOTE    8'h06
`define PSS_A_PWRITE    8'h07
`define PSS_A_OPMODE    8'h08
`define PSS_A_TMAP0     8'h09
`define PSS_A_TMAP4     8'h0d
`define PSS_A_STATUS    8'h0e
`define PSS_A_FREQ      8'h0f
`define PSS_A_PRESET0   8'h10
`define PSS_A_PRESET11  8'h1b

// ==========================================================================
// Reset values; frequencies in 0.1 Hz, times in 0.1 s.
`define PSS_RST_HIGH      16'h0258
`define PSS_RST_MIDDLE    16'h012c
`define PSS_RST_LOW       16'h0064
`define PSS_RST_INCH_FREQ 16'h0032
`define PSS_RST_INCH_RAMP 16'h0005
`define PSS_RST_RAMP_REF  16'h0258
`define PSS_RST_REMOTE    16'h0000
`define PSS_RST_PWRITE    16'h0000
`define PSS_RST_OPMODE    16'h0000
`define PSS_NOT_SELECTED  16'h270f

// ==========================================================================
// Setting limits.
`define PSS_MAX_FREQ    16'h0fa0
`define PSS_MAX_RAMP    16'h8ca0
`define PSS_MAX_REMOTE  16'h0003
`define PSS_MAX_PWRITE  16'h0002
`define PSS_MAX_OPMODE  16'h0004
`define PSS_MODE_EXT    16'h0003
`define PSS_MODE_COMB   16'h0004

// ==========================================================================
// Terminal function codes.
`define PSS_FN_LOW    8'h00
`define PSS_FN_MIDDLE 8'h01
`define PSS_FN_HIGH   8'h02
`define PSS_FN_INCH   8'h05
`define PSS_FN_EXTRA  8'h08
`define PSS_RST_TMAP0 8'h00
`define PSS_RST_TMAP1 8'h01
`define PSS_RST_TMAP2 8'h02
`define PSS_RST_TMAP3 8'h08
`define PSS_RST_TMAP4 8'h05

// ==========================================================================
// Command source codes.
`define PSS_SRC_NONE  3'h0
`define PSS_SRC_INCH  3'h1
`define PSS_SRC_MULTI 3'h2
`define PSS_SRC_CUR   3'h3
`define PSS_SRC_VOLT  3'h4

`endif

// ### pss_preset_mem.v
`timescale 1ns/1ps
`include "pss_map.vh"

// ==========================================================================
// Preset store for speeds 4 to 15 with two registered read ports.
module pss_preset_mem #(
  parameter DEPTH = 12,
  parameter AW    = 4,
  parameter DW    = 16
) (
  input  wire          clk,
  input  wire          srst,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr_a,
  output reg  [DW-1:0] rdata_a,
  input  wire [AW-1:0] raddr_b,
  output reg  [DW-1:0] rdata_b
);
  reg [DW-1:0] mem_q [0:DEPTH-1];
  integer i;

  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= `PSS_NOT_SELECTED;
      end
      rdata_a <= {DW{1'b0}};
      rdata_b <= {DW{1'b0}};
    end else begin
      if (we && (waddr < DEPTH)) begin
        mem_q[waddr] <= wdata;
      end
      rdata_a <= (raddr_a < DEPTH) ? mem_q[raddr_a] : {DW{1'b0}};
      rdata_b <= (raddr_b < DEPTH) ? mem_q[raddr_b] : {DW{1'b0}};
    end
  end
endmodule

// ### pss_speed_select.v
// Functional notes
// RULE1: High select runs high preset, default 60Hz.
// RULE2: Middle select runs middle preset, default 30Hz.
// RULE3: Low select runs low preset, default 10Hz.
// RULE4: Several of three on: lowest-ranked wins.
// RULE5: Speeds 4-15 from four select combinations.
// RULE6: Speeds 4-15 default to 9999, unselected.
// RULE7: Speed 8 unset, extra only: low preset.
// RULE8: Speeds 4-15 have no mutual priority.
// RULE9: Inching, multi-speed, current, voltage source order.
// RULE10: Multi-speed only in operation mode 3 or 4.
// RULE11: Remote selector nonzero disables multi-speed.
// RULE12: Preset writes always accepted, even running.
// RULE13: Function codes 0,1,2 map low, middle, high.
// RULE14: Function code 8 maps extra select.
// RULE15: Function code 5 maps inching select.
// RULE16: Inching runs inching frequency, default 5Hz.
// RULE17: Inching ramp default 0.5s, both directions.
// RULE18: Inching runs only while start held.
// RULE19: Inching works in external and panel modes.
// RULE20: Index is extra,high,middle,low, low is lsb.
// RULE21: Remote 1-3: high, middle, low become accel/decel/clear.
// RULE22: Inching disabled when operation mode is 3.
// RULE23: Configure inching frequency above starting frequency.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "pss_map.vh"

module pss_speed_select #(
  parameter NTERM = 5,
  parameter FW    = 16
) (
  input  wire             CLK,
  input  wire             SRST,
  input  wire [7:0]       ADDR,
  input  wire [15:0]      WDATA,
  input  wire             WR,
  input  wire             RD,
  output wire [15:0]      RDATA,
  input  wire [NTERM-1:0] TERM_IN,
  input  wire             FORWARD_START,
  input  wire             REVERSE_START,
  input  wire             PANEL_INCH_MODE,
  input  wire             PANEL_RUN,
  input  wire [FW-1:0]    CUR_FREQ,
  input  wire             CUR_VALID,
  input  wire [FW-1:0]    VOLT_FREQ,
  input  wire             VOLT_VALID,
  output reg  [FW-1:0]    FREQ_CMD,
  output reg  [2:0]       FREQ_SOURCE,
  output reg              RUN_FWD,
  output reg              RUN_REV,
  output reg              INCH_ACTIVE,
  output reg  [15:0]      INCH_RAMP_TIME,
  output reg  [FW-1:0]    RAMP_REF_FREQ,
  output reg              REMOTE_ACCEL,
  output reg              REMOTE_DECEL,
  output reg              REMOTE_CLEAR
);

  // ========================================================================
  // Configuration registers.
  reg [15:0] high_q;
  reg [15:0] middle_q;
  reg [15:0] low_q;
  reg [15:0] inch_freq_q;
  reg [15:0] inch_ramp_q;
  reg [15:0] ramp_ref_q;
  reg [15:0] remote_q;
  reg [15:0] pwrite_q;
  reg [15:0] opmode_q;
  reg [7:0]  tmap_q [0:NTERM-1];
  reg [15:0] rdata_q;
  reg        rd_mem_q;
  integer    k;
  integer    j;

  wire [15:0] mem_bus_data;
  wire [15:0] mem_sel_data;
  wire        freq_ok  = (WDATA <= `PSS_MAX_FREQ);
  wire        is_preset = (ADDR >= `PSS_A_PRESET0) && (ADDR <= `PSS_A_PRESET11);
  wire        preset_ok = freq_ok || (WDATA == `PSS_NOT_SELECTED);
  // Selector value 1 locks every setting except the presets and the selector itself.
  wire        locked   = (pwrite_q == 16'h0001);
  wire [7:0]  preset_off = ADDR - `PSS_A_PRESET0;
  wire [7:0]  tmap_off   = ADDR - `PSS_A_TMAP0;

  always @(posedge CLK) begin
    if (SRST) begin
      high_q      <= `PSS_RST_HIGH;
      middle_q    <= `PSS_RST_MIDDLE;
      low_q       <= `PSS_RST_LOW;
      inch_freq_q <= `PSS_RST_INCH_FREQ;
      inch_ramp_q <= `PSS_RST_INCH_RAMP;
      ramp_ref_q  <= `PSS_RST_RAMP_REF;
      remote_q    <= `PSS_RST_REMOTE;
      pwrite_q    <= `PSS_RST_PWRITE;
      opmode_q    <= `PSS_RST_OPMODE;
      tmap_q[0]   <= `PSS_RST_TMAP0;
      tmap_q[1]   <= `PSS_RST_TMAP1;
      tmap_q[2]   <= `PSS_RST_TMAP2;
      tmap_q[3]   <= `PSS_RST_TMAP3;
      tmap_q[4]   <= `PSS_RST_TMAP4;
    end else if (WR) begin
      case (ADDR)
        `PSS_A_HIGH: begin
          if (freq_ok) high_q <= WDATA; // RULE1 RULE12
        end
        `PSS_A_MIDDLE: begin
          if (freq_ok) middle_q <= WDATA; // RULE2 RULE12
        end
        `PSS_A_LOW: begin
          if (freq_ok) low_q <= WDATA; // RULE3 RULE12
        end
        `PSS_A_INCH_FREQ: begin
          if (freq_ok && !locked) inch_freq_q <= WDATA; // RULE16
        end
        `PSS_A_INCH_RAMP: begin
          if ((WDATA <= `PSS_MAX_RAMP) && !locked) inch_ramp_q <= WDATA; // RULE17
        end
        `PSS_A_RAMP_REF: begin
          if (freq_ok && !locked) ramp_ref_q <= WDATA;
        end
        `PSS_A_REMOTE: begin
          if ((WDATA <= `PSS_MAX_REMOTE) && !locked) remote_q <= WDATA;
        end
        `PSS_A_PWRITE: begin
          if (WDATA <= `PSS_MAX_PWRITE) pwrite_q <= WDATA;
        end
        `PSS_A_OPMODE: begin
          if ((WDATA <= `PSS_MAX_OPMODE) && !locked) opmode_q <= WDATA;
        end
        default: begin
          if ((ADDR >= `PSS_A_TMAP0) && (ADDR <= `PSS_A_TMAP4) && !locked) begin
            for (k = 0; k < NTERM; k = k + 1) begin
              if (tmap_off == k[7:0]) tmap_q[k] <= WDATA[7:0];
            end
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Preset store: port A serves the bus, port B serves speed selection.
  reg  [3:0] slot;
  reg  [3:0] idx_q;
  wire [3:0] idx;

  always @* begin
    case (idx)
      4'h3:    slot = 4'h0; // RULE5
      4'h5:    slot = 4'h1;
      4'h6:    slot = 4'h2;
      4'h7:    slot = 4'h3;
      default: slot = idx - 4'h4; // RULE5 RULE8
    endcase
  end

  pss_preset_mem #(
    .DEPTH (12),
    .AW    (4),
    .DW    (16)
  ) u_mem (
    .clk     (CLK),
    .srst    (SRST),
    .we      (WR && is_preset && preset_ok), // RULE6 RULE12
    .waddr   (preset_off[3:0]),
    .wdata   (WDATA),
    .raddr_a (preset_off[3:0]),
    .rdata_a (mem_bus_data),
    .raddr_b (slot),
    .rdata_b (mem_sel_data)
  );

  // ========================================================================
  // Terminal function map.
  reg sig_low;
  reg sig_middle;
  reg sig_high;
  reg sig_extra;
  reg sig_inch;
  integer t;

  always @* begin
    sig_low    = 1'b0;
    sig_middle = 1'b0;
    sig_high   = 1'b0;
    sig_extra  = 1'b0;
    sig_inch   = 1'b0;
    for (t = 0; t < NTERM; t = t + 1) begin
      if (TERM_IN[t]) begin
        if (tmap_q[t] == `PSS_FN_LOW) sig_low = 1'b1; // RULE13
        if (tmap_q[t] == `PSS_FN_MIDDLE) sig_middle = 1'b1; // RULE13
        if (tmap_q[t] == `PSS_FN_HIGH) sig_high = 1'b1; // RULE13
        if (tmap_q[t] == `PSS_FN_EXTRA) sig_extra = 1'b1; // RULE14
        if (tmap_q[t] == `PSS_FN_INCH) sig_inch = 1'b1; // RULE15
      end
    end
  end

  assign idx = {sig_extra, sig_high, sig_middle, sig_low}; // RULE20

  // ========================================================================
  // Stage one: sample inputs alongside the preset lookup.
  reg          fwd_q;
  reg          rev_q;
  reg          ext_inch_q;
  reg          pnl_inch_q;
  reg          pnl_run_q;
  reg [FW-1:0] cur_q;
  reg          cur_v_q;
  reg [FW-1:0] volt_q;
  reg          volt_v_q;

  always @(posedge CLK) begin
    if (SRST) begin
      idx_q      <= 4'h0;
      fwd_q      <= 1'b0;
      rev_q      <= 1'b0;
      ext_inch_q <= 1'b0;
      pnl_inch_q <= 1'b0;
      pnl_run_q  <= 1'b0;
      cur_q      <= {FW{1'b0}};
      cur_v_q    <= 1'b0;
      volt_q     <= {FW{1'b0}};
      volt_v_q   <= 1'b0;
    end else begin
      idx_q      <= idx;
      fwd_q      <= FORWARD_START;
      rev_q      <= REVERSE_START;
      ext_inch_q <= sig_inch;
      pnl_inch_q <= PANEL_INCH_MODE;
      pnl_run_q  <= PANEL_RUN;
      cur_q      <= CUR_FREQ;
      cur_v_q    <= CUR_VALID;
      volt_q     <= VOLT_FREQ;
      volt_v_q   <= VOLT_VALID;
    end
  end

  // ========================================================================
  // Stage two: pick the source and the frequency.
  wire mode_multi  = (opmode_q == `PSS_MODE_EXT) || (opmode_q == `PSS_MODE_COMB);
  wire remote_on   = (remote_q != 16'h0000);
  wire inch_allow  = (opmode_q != `PSS_MODE_EXT); // RULE22
  wire inch_ext    = ext_inch_q && inch_allow; // RULE19
  wire inch_pnl    = pnl_inch_q && !ext_inch_q && inch_allow; // RULE19
  wire multi_on    = mode_multi && !remote_on && (idx_q != 4'h0); // RULE10 RULE11
  wire combo       = (idx_q == 4'h3) || (idx_q >= 4'h5);

  reg [FW-1:0] three_freq;
  reg [FW-1:0] multi_freq;
  reg [FW-1:0] freq_d;
  reg [2:0]    src_d;
  reg          fwd_d;
  reg          rev_d;

  always @* begin
    if (idx_q[0] || (idx_q[2:0] == 3'h0)) begin
      three_freq = low_q; // RULE3 RULE4 RULE7
    end else if (idx_q[1]) begin
      three_freq = middle_q; // RULE2 RULE4
    end else begin
      three_freq = high_q; // RULE1
    end
    if (combo && (mem_sel_data != `PSS_NOT_SELECTED)) begin
      multi_freq = mem_sel_data; // RULE5 RULE6
    end else begin
      multi_freq = three_freq; // RULE4 RULE7
    end
  end

  always @* begin
    freq_d = {FW{1'b0}};
    src_d  = `PSS_SRC_NONE;
    fwd_d  = fwd_q && !rev_q;
    rev_d  = rev_q && !fwd_q;
    if (inch_ext || inch_pnl) begin
      freq_d = inch_freq_q; // RULE9 RULE16
      src_d  = `PSS_SRC_INCH;
      if (inch_pnl) begin
        fwd_d = pnl_run_q; // RULE18
        rev_d = 1'b0;
      end
    end else if (multi_on) begin
      freq_d = multi_freq; // RULE9
      src_d  = `PSS_SRC_MULTI;
    end else if (cur_v_q) begin
      freq_d = cur_q; // RULE9
      src_d  = `PSS_SRC_CUR;
    end else if (volt_v_q) begin
      freq_d = volt_q; // RULE9
      src_d  = `PSS_SRC_VOLT;
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      FREQ_CMD       <= {FW{1'b0}};
      FREQ_SOURCE    <= `PSS_SRC_NONE;
      RUN_FWD        <= 1'b0;
      RUN_REV        <= 1'b0;
      INCH_ACTIVE    <= 1'b0;
      INCH_RAMP_TIME <= `PSS_RST_INCH_RAMP;
      RAMP_REF_FREQ  <= `PSS_RST_RAMP_REF;
      REMOTE_ACCEL   <= 1'b0;
      REMOTE_DECEL   <= 1'b0;
      REMOTE_CLEAR   <= 1'b0;
    end else begin
      FREQ_CMD       <= freq_d;
      FREQ_SOURCE    <= src_d;
      RUN_FWD        <= fwd_d; // RULE18
      RUN_REV        <= rev_d; // RULE18
      INCH_ACTIVE    <= inch_ext || inch_pnl;
      INCH_RAMP_TIME <= inch_ramp_q; // RULE17
      RAMP_REF_FREQ  <= ramp_ref_q; // RULE17
      REMOTE_ACCEL   <= remote_on && idx_q[2]; // RULE21
      REMOTE_DECEL   <= remote_on && idx_q[1]; // RULE21
      REMOTE_CLEAR   <= remote_on && idx_q[0]; // RULE21
    end
  end

  // ========================================================================
  // Register read port.
  reg [15:0] rd_d;

  always @* begin
    case (ADDR)
      `PSS_A_HIGH:      rd_d = high_q;
      `PSS_A_MIDDLE:    rd_d = middle_q;
      `PSS_A_LOW:       rd_d = low_q;
      `PSS_A_INCH_FREQ: rd_d = inch_freq_q;
      `PSS_A_INCH_RAMP: rd_d = inch_ramp_q;
      `PSS_A_RAMP_REF:  rd_d = ramp_ref_q;
      `PSS_A_REMOTE:    rd_d = remote_q;
      `PSS_A_PWRITE:    rd_d = pwrite_q;
      `PSS_A_OPMODE:    rd_d = opmode_q;
      `PSS_A_STATUS:    rd_d = {6'h00, INCH_ACTIVE, RUN_REV, RUN_FWD, FREQ_SOURCE,
                                idx_q};
      `PSS_A_FREQ:      rd_d = FREQ_CMD;
      default: begin
        rd_d = 16'h0000;
        for (j = 0; j < NTERM; j = j + 1) begin
          if (tmap_off == j[7:0]) rd_d = {8'h00, tmap_q[j]};
        end
      end
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      rdata_q  <= 16'h0000;
      rd_mem_q <= 1'b0;
    end else begin
      rdata_q  <= RD ? rd_d : 16'h0000;
      rd_mem_q <= RD && is_preset;
    end
  end

  assign RDATA = rd_mem_q ? mem_bus_data : rdata_q;

endmodule

// ### pss_contacts.sv
`timescale 1ns/1ps
// ==========================================================================
// Contact bank: each switch closes on the clock edge after it is commanded.
module pss_contacts (
  input  wire        clk,
  input  wire [4:0]  want_term,
  input  wire        want_fwd,
  input  wire        want_rev,
  output logic [4:0] term,
  output logic       fwd,
  output logic       rev
);
  always @(posedge clk) begin
    term <= want_term;
    fwd  <= want_fwd;
    rev  <= want_rev;
  end
endmodule

// ### pss_speed_select_sva.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the speed selector.
module pss_sel_chk #(
  parameter FW = 16
) (
  input wire          CLK,
  input wire          SRST,
  input wire          RD,
  input wire [15:0]   RDATA,
  input wire          FORWARD_START,
  input wire          REVERSE_START,
  input wire          PANEL_RUN,
  input wire [FW-1:0] CUR_FREQ,
  input wire          CUR_VALID,
  input wire [FW-1:0] VOLT_FREQ,
  input wire          VOLT_VALID,
  input wire [FW-1:0] FREQ_CMD,
  input wire [2:0]    FREQ_SOURCE,
  input wire          RUN_FWD,
  input wire          RUN_REV,
  input wire          INCH_ACTIVE,
  input wire [15:0]   INCH_RAMP_TIME,
  input wire [FW-1:0] RAMP_REF_FREQ
);
  wire both_on = FORWARD_START & REVERSE_START & ~PANEL_RUN;
  wire none_on = ~(FORWARD_START | REVERSE_START | PANEL_RUN);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  property p_rd_idle;
    !$past(RD) |-> RDATA == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_none;
    $past(none_on, 2) |-> !RUN_FWD && !RUN_REV;
  endproperty
  a_none: assert property (p_none) else $error("run without start");
  property p_both;
    $past(both_on, 2) |-> !RUN_FWD && !RUN_REV;
  endproperty
  a_both: assert property (p_both) else $error("run with both starts");
  property p_excl;
    !(RUN_FWD && RUN_REV);
  endproperty
  a_excl: assert property (p_excl) else $error("both directions");
  property p_range;
    FREQ_SOURCE <= 3'h4;
  endproperty
  a_range: assert property (p_range) else $error("bad source code");
  property p_cur;
    FREQ_SOURCE == 3'h3 |-> $past(CUR_VALID, 2) && FREQ_CMD == $past(CUR_FREQ, 2);
  endproperty
  a_cur: assert property (p_cur) else $error("current input mismatch");
  property p_volt;
    FREQ_SOURCE == 3'h4 |-> !$past(CUR_VALID, 2) && FREQ_CMD == $past(VOLT_FREQ, 2);
  endproperty
  a_volt: assert property (p_volt) else $error("voltage input mismatch");
  property p_rst;
    $fell(SRST) |-> INCH_RAMP_TIME == 16'h0005 && RAMP_REF_FREQ == 16'h0258;
  endproperty
  a_rst: assert property (p_rst) else $error("ramp reset values");
  property p_inch;
    INCH_ACTIVE == (FREQ_SOURCE == 3'h1);
  endproperty
  a_inch: assert property (p_inch) else $error("inching flag and source disagree");
  property p_ramp_max;
    INCH_RAMP_TIME <= 16'h8ca0;
  endproperty
  a_ramp_max: assert property (p_ramp_max) else $error("inching ramp out of range");
  c_inch: cover property (FREQ_SOURCE == 3'h1);
  c_multi: cover property (FREQ_SOURCE == 3'h2);
  c_cur: cover property (FREQ_SOURCE == 3'h3);
endmodule

// ### pss_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the speed selector.
module testbench;
  logic        CLK = 1'h0;
  logic        SRST = 1'h1;
  logic [7:0]  ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'h0;
  logic        RD = 1'h0;
  logic        PANEL_INCH_MODE = 1'h0;
  logic        PANEL_RUN = 1'h0;
  logic [15:0] CUR_FREQ = 16'h0000;
  logic        CUR_VALID = 1'h0;
  logic [15:0] VOLT_FREQ = 16'h0000;
  logic        VOLT_VALID = 1'h0;
  logic [4:0]  want_term = 5'h00;
  logic        want_fwd = 1'h0;
  logic        want_rev = 1'h0;
  logic        chk = 1'h0;
  logic        rd_d = 1'h0;
  logic [31:0] seed = 32'ha80ac7f9;
  logic [15:0] r;
  logic [15:0] q_rd[$];
  logic [23:0] q_sel[$];
  int          miscompares = 0;
  int          compares = 0;
  wire  [15:0] RDATA;
  wire  [4:0]  TERM_IN;
  wire         FORWARD_START;
  wire         REVERSE_START;
  wire  [15:0] FREQ_CMD;
  wire  [2:0]  FREQ_SOURCE;
  wire         RUN_FWD;
  wire         RUN_REV;
  wire         INCH_ACTIVE;
  wire  [15:0] INCH_RAMP_TIME;
  wire  [15:0] RAMP_REF_FREQ;
  wire         REMOTE_ACCEL;
  wire         REMOTE_DECEL;
  wire         REMOTE_CLEAR;
  logic [15:0] dflt[14] = '{16'h0258, 16'h012c, 16'h0064, 16'h0032, 16'h0005, 16'h0258,
                            16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0002,
                            16'h0008, 16'h0005};
  logic [4:0]  tt[6] = '{5'h04, 5'h02, 5'h01, 5'h03, 5'h07, 5'h08};
  logic [15:0] ff[6] = '{16'h0064, 16'h012c, 16'h0258, 16'h012c, 16'h0064, 16'h0064};

  always #20 CLK = ~CLK;

  pss_contacts u_pss_contacts (.clk(CLK), .want_term(want_term), .want_fwd(want_fwd),
    .want_rev(want_rev), .term(TERM_IN), .fwd(FORWARD_START), .rev(REVERSE_START));

  pss_speed_select u_pss_speed_select (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .TERM_IN(TERM_IN), .FORWARD_START(FORWARD_START),
    .REVERSE_START(REVERSE_START), .PANEL_INCH_MODE(PANEL_INCH_MODE), .PANEL_RUN(PANEL_RUN),
    .CUR_FREQ(CUR_FREQ), .CUR_VALID(CUR_VALID), .VOLT_FREQ(VOLT_FREQ),
    .VOLT_VALID(VOLT_VALID), .FREQ_CMD(FREQ_CMD), .FREQ_SOURCE(FREQ_SOURCE),
    .RUN_FWD(RUN_FWD), .RUN_REV(RUN_REV), .INCH_ACTIVE(INCH_ACTIVE),
    .INCH_RAMP_TIME(INCH_RAMP_TIME),
    .RAMP_REF_FREQ(RAMP_REF_FREQ), .REMOTE_ACCEL(REMOTE_ACCEL), .REMOTE_DECEL(REMOTE_DECEL),
    .REMOTE_CLEAR(REMOTE_CLEAR));

  // ==========================================================================
  // Stimulus helpers.
  function automatic logic [15:0] rnd_freq();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return 16'(seed % 32'h00000fa1);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    WR <= 1'h1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge CLK);
    RD <= 1'h1;
    ADDR <= a;
    q_rd.push_back(e);
    @(posedge CLK);
    RD <= 1'h0;
  endtask

  // Contacts settle through the bank and the selector pipeline before the look.
  task automatic sel(input logic [4:0] t, input logic [2:0] s, input logic [15:0] f,
                     input logic [1:0] run = 2'h0, input logic [2:0] rem = 3'h0);
    @(posedge CLK);
    want_term <= t;
    repeat (5) @(posedge CLK);
    q_sel.push_back({run, rem, s, f});
    chk <= 1'h1;
    @(posedge CLK);
    chk <= 1'h0;
  endtask

  // ==========================================================================
  // Result watcher.
  task automatic cmp_rd(input logic [15:0] got);
    logic [15:0] e;
    e = q_rd.pop_front();
    compares++;
    if (got !== e) begin
      miscompares++;
      $display("Error at %0t: read %h expected %h", $time, got, e);
    end
  endtask

  task automatic cmp_sel(input logic [23:0] got);
    logic [23:0] e;
    e = q_sel.pop_front();
    compares++;
    if (got !== e) begin
      miscompares++;
      $display("Error at %0t: selection %h expected %h", $time, got, e);
    end
  endtask

  always @(posedge CLK) begin
    rd_d <= RD;
    if (rd_d) cmp_rd(RDATA);
    if (chk) cmp_sel({RUN_FWD, RUN_REV, REMOTE_ACCEL, REMOTE_DECEL, REMOTE_CLEAR,
                      FREQ_SOURCE, FREQ_CMD});
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    wrap_up();
  end

  // ==========================================================================
  // Main sequence; terminals remapped to bit0 high, bit2 low.
  initial begin
    repeat (8) @(posedge CLK);
    SRST <= 1'h0;
    foreach (dflt[i]) rd(8'(i), dflt[i]);
    rd(8'h10, 16'h270f);
    rd(8'h1b, 16'h270f);
    rd(8'h20, 16'h0000);
    wr(8'h09, 16'h0002);
    wr(8'h0b, 16'h0000);
    wr(8'h04, 16'h8ca0);
    wr(8'h04, 16'h8ca1);
    rd(8'h04, 16'h8ca0);
    wr(8'h08, 16'h0003);
    foreach (tt[i]) sel(tt[i], 3'h2, ff[i]);
    wr(8'h07, 16'h0001);
    r = rnd_freq();
    wr(8'h14, r);
    wr(8'h00, 16'h0001);
    rd(8'h00, 16'h0001);
    sel(5'h08, 3'h2, r);
    wr(8'h07, 16'h0000);
    r = rnd_freq();
    wr(8'h1b, r);
    sel(5'h0f, 3'h2, r);
    sel(5'h05, 3'h2, 16'h0064);
    sel(5'h0b, 3'h2, 16'h012c);
    r = rnd_freq();
    CUR_FREQ <= r;
    VOLT_FREQ <= rnd_freq();
    CUR_VALID <= 1'h1;
    VOLT_VALID <= 1'h1;
    sel(5'h00, 3'h3, r);
    sel(5'h04, 3'h2, 16'h0064);
    CUR_VALID <= 1'h0;
    sel(5'h00, 3'h4, VOLT_FREQ);
    CUR_VALID <= 1'h1;
    wr(8'h08, 16'h0000);
    sel(5'h04, 3'h3, CUR_FREQ);
    wr(8'h08, 16'h0004);
    sel(5'h04, 3'h2, 16'h0064);
    wr(8'h03, 16'h0032);
    want_fwd <= 1'h1;
    sel(5'h14, 3'h1, 16'h0032, 2'h2);
    want_rev <= 1'h1;
    sel(5'h14, 3'h1, 16'h0032);
    want_fwd <= 1'h0;
    sel(5'h14, 3'h1, 16'h0032, 2'h1);
    want_rev <= 1'h0;
    sel(5'h14, 3'h1, 16'h0032);
    PANEL_INCH_MODE <= 1'h1;
    PANEL_RUN <= 1'h1;
    sel(5'h00, 3'h1, 16'h0032, 2'h2);
    PANEL_INCH_MODE <= 1'h0;
    PANEL_RUN <= 1'h0;
    wr(8'h08, 16'h0003);
    sel(5'h14, 3'h2, 16'h0064);
    wr(8'h06, 16'h0001);
    sel(5'h01, 3'h3, CUR_FREQ, 2'h0, 3'h4);
    sel(5'h02, 3'h3, CUR_FREQ, 2'h0, 3'h2);
    sel(5'h04, 3'h3, CUR_FREQ, 2'h0, 3'h1);
    rd(8'h0f, CUR_FREQ);
    rd(8'h0e, 16'h0031);
    repeat (4) @(posedge CLK);
    wrap_up();
  end
endmodule

bind pss_speed_select pss_sel_chk #(.FW(FW)) u_pss_sel_chk (.CLK(CLK), .SRST(SRST),
  .RD(RD), .RDATA(RDATA), .FORWARD_START(FORWARD_START), .REVERSE_START(REVERSE_START),
  .PANEL_RUN(PANEL_RUN), .CUR_FREQ(CUR_FREQ), .CUR_VALID(CUR_VALID),
  .VOLT_FREQ(VOLT_FREQ), .VOLT_VALID(VOLT_VALID), .FREQ_CMD(FREQ_CMD),
  .FREQ_SOURCE(FREQ_SOURCE), .RUN_FWD(RUN_FWD), .RUN_REV(RUN_REV),
  .INCH_ACTIVE(INCH_ACTIVE), .INCH_RAMP_TIME(INCH_RAMP_TIME), .RAMP_REF_FREQ(RAMP_REF_FREQ));
